// file: dcm_pkg.sv
// Constants and carrier types for the DDR2 command and mode logic.
package dcm_pkg;
  localparam int ROW_W = 2;
  localparam int COL_W = 4;
  localparam int DQ_W = 16;
  localparam int REF_W = 4;
  localparam int BANK_W = 2;
  localparam int POST_LAT_MAX = 7;
  localparam int CLK_PERIOD_NS = 100;
  localparam int PRE_PERIOD_NS = 15;
  localparam int PRE_CYC_RAW = (PRE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] PRE_CYC = 4'(PRE_CYC_RAW < 1 ? 1 : PRE_CYC_RAW);
  localparam int AP_BIT = 10;
  localparam int DLL_RST_BIT = 8;
  localparam int ORDER_BIT = 3;
  localparam int LEN_LSB = 0;
  localparam int RL_LSB = 4;
  localparam int POST_LAT_LSB = 3;
  localparam logic [2:0] BL4_CODE = 3'h2;
  localparam logic [2:0] BL8_CODE = 3'h3;
  localparam logic [2:0] WAIT_TRIM = 3'h2;
  localparam logic [1:0] CFG_SEL = 2'h0;
  localparam logic [1:0] EMR_SEL = 2'h1;
  localparam logic [16:0] CFG_RST = 17'h00032;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;

  typedef enum logic [1:0] {
    DCM_RUN = 2'b01,
    DCM_SREF = 2'b10
  } dcm_mode_e;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } dcm_cmd_s;

  typedef struct packed {
    logic vld;
    logic wr;
    logic ap;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0] col;
  } dcm_acc_s;
endpackage : dcm_pkg

// file: dcm_skid.sv
// Small shift-register buffer for read data with valid and ready on both sides.
`timescale 1ns/1ps
module dcm_skid #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  typedef struct packed {
    logic [DEPTH-1:0] vld;
    logic [DEPTH-1:0][WIDTH-1:0] dat;
  } dcm_skid_st_s;

  dcm_skid_st_s s_reg;
  dcm_skid_st_s s_next;

  always_comb begin
    logic placed;
    s_next = s_reg;
    placed = 1'b0;
    if (out_ready_i && s_reg.vld[0]) begin
      for (int i = 0; i < DEPTH; i++) begin
        s_next.vld[i] = (i < DEPTH - 1) ? s_reg.vld[i + 1] : 1'b0;
        s_next.dat[i] = (i < DEPTH - 1) ? s_reg.dat[i + 1] : s_reg.dat[i];
      end
    end
    // A word is refused while the last slot is full, so the source must hold it.
    if (in_valid_i && !s_reg.vld[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!placed && !s_next.vld[i]) begin
          s_next.vld[i] = 1'b1;
          s_next.dat[i] = in_data_i;
          placed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign in_ready_o = !s_reg.vld[DEPTH-1];
  assign out_valid_o = s_reg.vld[0];
  assign out_data_o = s_reg.dat[0];
endmodule : dcm_skid

// file: dcm_core.sv
// Command decoder, bank state, burst engine and storage of the DDR2 device.
`timescale 1ns/1ps
module dcm_core #(
  parameter int ROW_W = dcm_pkg::ROW_W,
  parameter int DQ_W = dcm_pkg::DQ_W,
  parameter int REF_W = dcm_pkg::REF_W
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic cke_i,
  input wire dcm_pkg::dcm_cmd_s cmd_i,
  input wire logic [2:0] ba_i,
  input wire logic [13:0] addr_i,
  input wire logic [DQ_W-1:0] wr_data_i,
  input wire logic [DQ_W/8-1:0] write_byte_mask_i,
  input wire logic rd_ready_i,
  output logic [DQ_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic [3:0] bank_open_o,
  output logic dll_enabled_o,
  output logic self_refresh_o,
  output logic [REF_W-1:0] refresh_row_o,
  output logic [16:0] operating_config_word_o
);
  localparam int COL_W = dcm_pkg::COL_W;
  localparam int BANKS = 4;
  localparam int MASK_W = DQ_W / 8;
  localparam int IDX_W = dcm_pkg::BANK_W + ROW_W + COL_W;
  localparam int WORDS = 1 << IDX_W;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [16:0] mode;
    logic [2:0] post_lat;
    dcm_pkg::dcm_mode_e mst;
    logic dll_on;
    logic [BANKS-1:0] open;
    logic [BANKS-1:0][ROW_W-1:0] row;
    logic [BANKS-1:0][3:0] pre_cnt;
    dcm_pkg::dcm_acc_s [dcm_pkg::POST_LAT_MAX-1:0] pipe;
    logic bact;
    logic bwr;
    logic bap;
    logic [dcm_pkg::BANK_W-1:0] bbank;
    logic [COL_W-1:0] bcol;
    logic [2:0] beat;
    logic [2:0] wait_cnt;
    logic [REF_W-1:0] ref_row;
    logic [WORDS-1:0][DQ_W-1:0] mem;
  } dcm_core_st_s;

  localparam dcm_core_st_s ST_RST = '{
    mode: dcm_pkg::CFG_RST,
    mst: dcm_pkg::DCM_RUN,
    dll_on: 1'b1,
    default: '0
  };

  // ----------------------------------------------------------------
  // Burst ordering
  // ----------------------------------------------------------------
  function automatic logic [2:0] burst_off(input logic [2:0] st, input logic [2:0] bt,
                                           input logic bl8, input logic ilv);
    logic [2:0] o;
    if (ilv) begin
      o = st ^ bt;
    end else begin
      o = {st[2] ^ bt[2], 2'(st[1:0] + bt[1:0])};
    end
    if (!bl8) begin
      o[2] = st[2];
    end
    return o;
  endfunction : burst_off

  dcm_core_st_s s_reg;
  dcm_core_st_s s_next;
  dcm_pkg::dcm_acc_s acc;
  dcm_pkg::dcm_acc_s exec;
  logic [3:0] code;
  logic go;
  logic bl8;
  logic ilv;
  logic [2:0] cur_off;
  logic [2:0] last_beat;
  logic [IDX_W-1:0] idx;
  logic push;
  logic [DQ_W-1:0] pdata;
  logic buf_rdy;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    acc = '0;
    push = 1'b0;
    code = {cmd_i.cs_n, cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
    go = cke_i && (s_reg.mst == dcm_pkg::DCM_RUN);
    bl8 = s_reg.mode[dcm_pkg::LEN_LSB +: 3] == dcm_pkg::BL8_CODE;
    ilv = s_reg.mode[dcm_pkg::ORDER_BIT];
    last_beat = bl8 ? 3'h7 : 3'h3;
    cur_off = burst_off(s_reg.bcol[2:0], s_reg.beat, bl8, ilv);
    idx = {s_reg.bbank, s_reg.row[s_reg.bbank], s_reg.bcol[COL_W-1:3], cur_off};
    pdata = s_reg.mem[idx];

    // The delay-locked loop reset is taken at once, so the bit clears next cycle.
    if (s_reg.mode[dcm_pkg::DLL_RST_BIT]) begin
      s_next.mode[dcm_pkg::DLL_RST_BIT] = 1'b0;
      s_next.dll_on = 1'b1;
    end

    for (int b = 0; b < BANKS; b++) begin
      if (s_reg.pre_cnt[b] != 4'h0) begin
        s_next.pre_cnt[b] = s_reg.pre_cnt[b] - 4'h1;
      end
    end

    s_next.pipe = {dcm_pkg::dcm_acc_s'('0), s_reg.pipe[dcm_pkg::POST_LAT_MAX-1:1]};

    // Burst engine: count down latency, then one beat per cycle while writing or while the read buffer has room.
    if (s_reg.bact) begin
      if (s_reg.wait_cnt != 3'h0) begin
        s_next.wait_cnt = s_reg.wait_cnt - 3'h1;
      end else if (s_reg.bwr || buf_rdy) begin
        if (s_reg.bwr) begin
          for (int i = 0; i < MASK_W; i++) begin
            if (!write_byte_mask_i[i]) begin
              s_next.mem[idx][8*i +: 8] = wr_data_i[8*i +: 8];
            end
          end
        end else begin
          push = 1'b1;
        end
        s_next.beat = s_reg.beat + 3'h1;
        if (s_reg.beat == last_beat) begin
          s_next.bact = 1'b0;
          if (s_reg.bap) begin
            s_next.open[s_reg.bbank] = 1'b0;
            s_next.pre_cnt[s_reg.bbank] = dcm_pkg::PRE_CYC;
          end
        end
      end
    end

    // Command decode; deselect and no-operation fall through untouched.
    unique case (s_reg.mst)
      dcm_pkg::DCM_RUN: begin
        if (!cke_i && code == dcm_pkg::CMD_REF) begin
          s_next.mst = dcm_pkg::DCM_SREF;
          s_next.dll_on = 1'b0;
        end else if (cke_i) begin
          case (code)
            dcm_pkg::CMD_MRS: begin
              if (ba_i[1:0] == dcm_pkg::CFG_SEL) begin
                s_next.mode = {ba_i, addr_i};
              end else if (ba_i[1:0] == dcm_pkg::EMR_SEL) begin
                s_next.post_lat = addr_i[dcm_pkg::POST_LAT_LSB +: 3];
              end
            end
            dcm_pkg::CMD_REF: begin
              s_next.ref_row = s_reg.ref_row + 1'b1;
            end
            dcm_pkg::CMD_ACT: begin
              s_next.open[ba_i[1:0]] = 1'b1;
              s_next.row[ba_i[1:0]] = addr_i[ROW_W-1:0];
            end
            dcm_pkg::CMD_PRE: begin
              for (int b = 0; b < BANKS; b++) begin
                if (addr_i[dcm_pkg::AP_BIT] || ba_i[1:0] == 2'(b)) begin
                  s_next.open[b] = 1'b0;
                  s_next.pre_cnt[b] = dcm_pkg::PRE_CYC;
                end
              end
            end
            dcm_pkg::CMD_RD, dcm_pkg::CMD_WR: begin
              acc.vld = 1'b1;
              acc.wr = (code == dcm_pkg::CMD_WR);
              acc.ap = addr_i[dcm_pkg::AP_BIT];
              acc.bank = ba_i[1:0];
              acc.col = addr_i[COL_W-1:0];
            end
            default: begin
            end
          endcase
        end
      end
      dcm_pkg::DCM_SREF: begin
        if (cke_i) begin
          s_next.mst = dcm_pkg::DCM_RUN;
          s_next.dll_on = 1'b1;
        end
      end
      default: begin
        s_next.mst = dcm_pkg::DCM_RUN;
      end
    endcase

    // Posted accesses wait in the pipe until their turn.
    if (s_reg.post_lat == 3'h0) begin
      exec = acc;
    end else begin
      exec = s_reg.pipe[0];
      s_next.pipe[3'(s_reg.post_lat - 3'h1)] = acc;
    end

    // Any bank may start a burst, including while another auto precharges.
    if (exec.vld) begin
      s_next.bact = 1'b1;
      s_next.bwr = exec.wr;
      s_next.bap = exec.ap;
      s_next.bbank = exec.bank;
      s_next.bcol = exec.col;
      s_next.beat = 3'h0;
      s_next.wait_cnt = s_reg.mode[dcm_pkg::RL_LSB +: 3] - dcm_pkg::WAIT_TRIM;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      s_reg <= ST_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Read data buffer
  // ----------------------------------------------------------------
  dcm_skid #(
    .WIDTH(DQ_W),
    .DEPTH(2)
  ) u_buf (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .in_valid_i(push),
    .in_data_i(pdata),
    .in_ready_o(buf_rdy),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o),
    .out_ready_i(rd_ready_i)
  );

  assign bank_open_o = s_reg.open;
  assign dll_enabled_o = s_reg.dll_on;
  assign self_refresh_o = s_reg.mst[1];
  assign refresh_row_o = s_reg.ref_row;
  assign operating_config_word_o = s_reg.mode;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  sequence sr_enter_s;
    s_reg.mst == dcm_pkg::DCM_RUN && !cke_i && code == dcm_pkg::CMD_REF;
  endsequence

  sequence sr_leave_s;
    s_reg.mst == dcm_pkg::DCM_SREF && cke_i;
  endsequence

  sequence rd_reg_s;
    go && code == dcm_pkg::CMD_RD && s_reg.post_lat == 3'h0 && !s_reg.bact && !rd_valid_o
      && s_reg.mode[dcm_pkg::RL_LSB +: 3] == 3'h3;
  endsequence

  sequence posted_s;
    go && code == dcm_pkg::CMD_RD && s_reg.post_lat == 3'h2 && !s_reg.bact && s_reg.pipe == '0;
  endsequence

  mode_load_a: assert property (
    go && code == dcm_pkg::CMD_MRS && ba_i[1:0] == dcm_pkg::CFG_SEL
      |=> s_reg.mode[7:0] == $past(addr_i[7:0]))
    else $error("mode word not loaded from address inputs");

  dll_self_clear_a: assert property (
    s_reg.mode[dcm_pkg::DLL_RST_BIT] |=> !s_reg.mode[dcm_pkg::DLL_RST_BIT])
    else $error("dll reset bit did not clear");

  row_open_a: assert property (
    go && code == dcm_pkg::CMD_ACT
      |=> s_reg.open[$past(ba_i[1:0])]
        && s_reg.row[$past(ba_i[1:0])] == $past(addr_i[ROW_W-1:0]))
    else $error("activate did not open the row");

  precharge_all_a: assert property (
    go && code == dcm_pkg::CMD_PRE && addr_i[dcm_pkg::AP_BIT] |=> s_reg.open == '0)
    else $error("precharge all left a bank open");

  pre_restart_a: assert property (
    go && code == dcm_pkg::CMD_PRE |=> s_reg.pre_cnt[$past(ba_i[1:0])] == dcm_pkg::PRE_CYC)
    else $error("precharge period not restarted");

  refresh_row_a: assert property (
    go && code == dcm_pkg::CMD_REF |=> s_reg.ref_row == REF_W'($past(s_reg.ref_row) + 1'b1))
    else $error("refresh row did not advance");

  dll_sleep_a: assert property (
    sr_enter_s |=> !s_reg.dll_on && self_refresh_o ##1 (dll_enabled_o == !self_refresh_o))
    else $error("dll state wrong on self refresh entry");

  dll_wake_a: assert property (
    sr_leave_s |=> s_reg.dll_on && !self_refresh_o)
    else $error("dll not back on at self refresh exit");

  deselect_a: assert property (
    cmd_i.cs_n |=> s_reg.ref_row == $past(s_reg.ref_row)
      && s_reg.post_lat == $past(s_reg.post_lat))
    else $error("deselect changed device state");

  read_lat_a: assert property (
    rd_reg_s |-> !rd_valid_o[*3] ##1 rd_valid_o)
    else $error("first read data not at read latency");

  posted_a: assert property (
    posted_s |=> !s_reg.bact[*2] ##1 s_reg.bact)
    else $error("posted access not delayed by latency");

  nibble_a: assert property (
    s_reg.bact && s_reg.wait_cnt == 3'h0 && bl8 && !ilv && s_reg.beat == 3'h4
      |-> cur_off == {~s_reg.bcol[2], s_reg.bcol[1:0]})
    else $error("sequential burst left the nibble order");

  block_wrap_a: assert property (
    s_reg.bact && !bl8 |-> cur_off[2] == s_reg.bcol[2])
    else $error("four-beat burst left its block");

  mask_hold_a: assert property (
    s_reg.bact && s_reg.bwr && s_reg.wait_cnt == 3'h0 && write_byte_mask_i == '1
      |=> s_reg.mem == $past(s_reg.mem))
    else $error("masked write changed storage");

  auto_close_a: assert property (
    s_reg.bact && s_reg.bap && s_reg.wait_cnt == 3'h0 && s_reg.beat == last_beat
      && (s_reg.bwr || buf_rdy) && !exec.vld && !(go && code == dcm_pkg::CMD_ACT)
      |=> !s_reg.open[$past(s_reg.bbank)])
    else $error("auto precharge did not close the row");
endmodule : dcm_core

// file: dcm_ctrl_model.sv
// Behavioural memory controller that drives commands and write beats into the device.
`timescale 1ns/1ps
module dcm_ctrl_model #(
  parameter int GAP = 2,
  parameter int PRE = 1,
  parameter int RCD = 2
) (
  input wire logic clk_i,
  output logic cke_o,
  output dcm_pkg::dcm_cmd_s cmd_o,
  output logic [2:0] ba_o,
  output logic [13:0] addr_o,
  output logic [15:0] wr_data_o,
  output logic [1:0] mask_o
);
  time t_cmd;

  initial begin
    t_cmd = 0;
    cke_o = 1'b1;
    cmd_o = 4'hf;
    ba_o = 3'h5;
    addr_o = 14'h2aaa;
    wr_data_o = 16'h55aa;
    mask_o = 2'h2;
  end

  // Address lines flip to the inverse once the command has been taken.
  task automatic issue(input logic [3:0] code, input logic [2:0] ba, input logic [13:0] addr,
                       input logic cke);
    @(posedge clk_i);
    t_cmd = $time;
    cke_o <= cke;
    cmd_o <= code;
    ba_o <= ba;
    addr_o <= addr;
    @(posedge clk_i);
    cmd_o <= 4'h7;
    ba_o <= ~ba;
    addr_o <= ~addr;
    if (code == dcm_pkg::CMD_MRS) begin
      repeat (GAP) @(posedge clk_i);
    end else if (code == dcm_pkg::CMD_PRE) begin
      repeat (PRE) @(posedge clk_i);
    end else if (code == dcm_pkg::CMD_ACT) begin
      repeat (RCD) @(posedge clk_i);
    end
  endtask : issue

  // Beat k is presented lat-1+k cycles after the command cycle.
  task automatic write_burst(input logic [1:0] bank, input logic [13:0] addr, input int lat,
                             input int n, input logic [15:0] d [8], input logic [1:0] m [8]);
    issue(dcm_pkg::CMD_WR, {1'b0, bank}, addr, 1'b1);
    repeat (lat - 2) @(posedge clk_i);
    for (int k = 0; k < n; k++) begin
      wr_data_o <= d[k];
      mask_o <= m[k];
      @(posedge clk_i);
    end
    wr_data_o <= ~d[n-1];
    mask_o <= ~m[n-1];
  endtask : write_burst
endmodule : dcm_ctrl_model

// file: test_ddr2_command_and_mode_logic.sv
// Self-checking testbench for the DDR2 command and mode logic.
`timescale 1ns/1ps
module test_ddr2_command_and_mode_logic;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic rd_ready_i = 1'b1;
  logic cke;
  dcm_pkg::dcm_cmd_s cmd;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [15:0] wr_data;
  logic [1:0] mask;
  logic [15:0] rd_data_o;
  logic rd_valid_o;
  logic [3:0] bank_open_o;
  logic dll_enabled_o;
  logic self_refresh_o;
  logic [3:0] refresh_row_o;
  logic [16:0] operating_config_word_o;
  logic [15:0] mem [256];
  logic [15:0] rq [$];
  logic [1:0] m0 [8] = '{default: 2'h0};
  logic [1:0] mk [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
  time t_first = 0;
  int num_errors = 0;
  int num_checks = 0;
  int lat = 3;
  logic bl8_m = 1'b0;
  logic ilv_m = 1'b0;

  always #50 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
      if (rq.size() == 0) begin
        t_first = $time;
      end
      rq.push_back(rd_data_o);
    end
  end

  dcm_ctrl_model u_ctrl (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd), .ba_o(ba), .addr_o(addr),
    .wr_data_o(wr_data), .mask_o(mask));

  dcm_core u_dut (.clk_i(clk_i), .reset_i(reset_i), .cke_i(cke), .cmd_i(cmd), .ba_i(ba),
    .addr_i(addr), .wr_data_i(wr_data), .write_byte_mask_i(mask), .rd_ready_i(rd_ready_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .bank_open_o(bank_open_o),
    .dll_enabled_o(dll_enabled_o), .self_refresh_o(self_refresh_o),
    .refresh_row_o(refresh_row_o), .operating_config_word_o(operating_config_word_o));

  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [3:0] ecol(input logic [3:0] s, input int k, input logic b8,
                                      input logic il);
    logic [2:0] kk;
    kk = 3'(k);
    if (il) return b8 ? {s[3], s[2:0] ^ kk} : {s[3:2], s[1:0] ^ kk[1:0]};
    return b8 ? {s[3], s[2] ^ kk[2], 2'(s[1:0] + kk[1:0])} : {s[3:2], 2'(s[1:0] + kk[1:0])};
  endfunction : ecol

  task automatic cmd1(input logic [3:0] code, input logic [2:0] b, input logic [13:0] a);
    u_ctrl.issue(code, b, a, 1'b1);
    #1;
  endtask : cmd1

  // All banks are closed first, since mode loads need every bank idle.
  task automatic set_mode(input logic b8, input logic il, input int rdlat, input int plat);
    logic [13:0] w;
    w = {7'h00, 3'(rdlat), il, (b8 ? dcm_pkg::BL8_CODE : dcm_pkg::BL4_CODE)};
    cmd1(dcm_pkg::CMD_PRE, 3'h0, 14'h0400);
    cmd1(dcm_pkg::CMD_MRS, 3'h1, 14'(plat << dcm_pkg::POST_LAT_LSB));
    cmd1(dcm_pkg::CMD_MRS, 3'h0, w);
    chk("mode word", {3'h0, w}, operating_config_word_o);
    bl8_m = b8;
    ilv_m = il;
    lat = rdlat + plat;
  endtask : set_mode

  task automatic wr(input logic [1:0] b, input logic [1:0] r, input logic [3:0] c,
                    input logic [15:0] base, input logic [1:0] m [8]);
    logic [15:0] d [8];
    logic [3:0] cc;
    int n;
    n = bl8_m ? 8 : 4;
    for (int k = 0; k < 8; k++) begin
      cc = ecol(c, k, bl8_m, ilv_m);
      d[k] = base | 16'(cc);
      if (k < n && !m[k][0]) mem[{b, r, cc}][7:0] = d[k][7:0];
      if (k < n && !m[k][1]) mem[{b, r, cc}][15:8] = d[k][15:8];
    end
    u_ctrl.write_burst(b, {10'h000, c}, lat, n, d, m);
  endtask : wr

  task automatic cmp_beats(input logic [1:0] b, input logic [1:0] r, input logic [3:0] c);
    int n;
    n = bl8_m ? 8 : 4;
    chk("beat count", 17'(n), 17'(rq.size()));
    for (int k = 0; k < n && k < rq.size(); k++) begin
      chk("read beat", {1'b0, mem[{b, r, ecol(c, k, bl8_m, ilv_m)}]}, {1'b0, rq[k]});
    end
  endtask : cmp_beats

  task automatic rd(input logic [1:0] b, input logic [1:0] r, input logic [3:0] c,
                    input logic ap);
    rq.delete();
    cmd1(dcm_pkg::CMD_RD, {1'b0, b}, {3'h0, ap, 6'h00, c});
    for (int i = 0; i < 80 && rq.size() < (bl8_m ? 8 : 4); i++) @(posedge clk_i);
    #1;
    cmp_beats(b, r, c);
    chk("read latency", 17'(lat + 1), 17'((t_first - u_ctrl.t_cmd) / 100));
  endtask : rd

  task automatic t_reset();
    #1;
    chk("reset word", 17'h00032, operating_config_word_o);
    chk("reset flags", 17'h00001, {10'h0, bank_open_o, rd_valid_o, self_refresh_o,
      dll_enabled_o});
    chk("reset row", 17'h0, {13'h0, refresh_row_o});
  endtask : t_reset

  task automatic t_mode();
    set_mode(1'b1, 1'b0, 3, 0);
    cmd1(dcm_pkg::CMD_MRS, 3'h0, 14'h0143);
    chk("dll reset clears", 17'h00043, operating_config_word_o);
    chk("dll on", 17'h1, {16'h0, dll_enabled_o});
    cmd1(dcm_pkg::CMD_MRS, 3'h2, 14'h0ff7);
    chk("ignored load", 17'h00043, operating_config_word_o);
  endtask : t_mode

  task automatic t_rw();
    set_mode(1'b1, 1'b0, 3, 0);
    cmd1(dcm_pkg::CMD_ACT, 3'h1, 14'h0002);
    chk("bank open", 17'h2, {13'h0, bank_open_o});
    wr(2'h1, 2'h2, 4'h0, 16'ha500, m0);
    wr(2'h1, 2'h2, 4'h8, 16'h5a00, m0);
    for (int o = 0; o < 2; o++) begin
      for (int b = 0; b < 2; b++) begin
        set_mode(b[0], o[0], o ? 7 : 3, 0);
        cmd1(dcm_pkg::CMD_ACT, 3'h1, 14'h0002);
        for (int s = 0; s < 16; s++) rd(2'h1, 2'h2, 4'(s), 1'b0);
        chk("row kept", 17'h2, {13'h0, bank_open_o});
      end
    end
  endtask : t_rw

  task automatic t_mask();
    set_mode(1'b0, 1'b0, 3, 0);
    cmd1(dcm_pkg::CMD_ACT, 3'h1, 14'h0002);
    wr(2'h1, 2'h2, 4'h8, 16'hc300, mk);
    rd(2'h1, 2'h2, 4'h8, 1'b0);
  endtask : t_mask

  task automatic t_posted();
    set_mode(1'b1, 1'b0, 3, 2);
    cmd1(dcm_pkg::CMD_ACT, 3'h1, 14'h0002);
    wr(2'h1, 2'h2, 4'h0, 16'h7700, m0);
    rd(2'h1, 2'h2, 4'h3, 1'b0);
    @(posedge clk_i);
    rd_ready_i <= 1'b0;
    rq.delete();
    cmd1(dcm_pkg::CMD_RD, 3'h1, 14'h0005);
    repeat (20) @(posedge clk_i);
    #1;
    chk("stalled valid", 17'h1, {16'h0, rd_valid_o});
    chk("stalled taken", 17'h0, 17'(rq.size()));
    @(posedge clk_i);
    rd_ready_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    #1;
    cmp_beats(2'h1, 2'h2, 4'h5);
  endtask : t_posted

  task automatic t_ap();
    set_mode(1'b0, 1'b0, 3, 0);
    cmd1(dcm_pkg::CMD_ACT, 3'h1, 14'h0002);
    cmd1(dcm_pkg::CMD_ACT, 3'h2, 14'h0001);
    wr(2'h2, 2'h1, 4'h4, 16'h3c00, m0);
    rd(2'h1, 2'h2, 4'h0, 1'b1);
    @(posedge clk_i);
    #1;
    chk("auto precharge", 17'h4, {13'h0, bank_open_o});
    rd(2'h2, 2'h1, 4'h4, 1'b0);
  endtask : t_ap

  task automatic t_pre();
    cmd1(dcm_pkg::CMD_PRE, 3'h2, 14'h0000);
    chk("precharge one", 17'h0, {13'h0, bank_open_o});
    cmd1(dcm_pkg::CMD_PRE, 3'h2, 14'h0000);
    cmd1(dcm_pkg::CMD_ACT, 3'h2, 14'h0003);
    cmd1(dcm_pkg::CMD_ACT, 3'h0, 14'h0000);
    cmd1(dcm_pkg::CMD_ACT, 3'h3, 14'h0001);
    chk("idle precharge", 17'hd, {13'h0, bank_open_o});
    cmd1(dcm_pkg::CMD_PRE, 3'h1, 14'h0400);
    chk("precharge all", 17'h0, {13'h0, bank_open_o});
    cmd1(4'hb, 3'h1, 14'h0002);
    cmd1(4'h7, 3'h1, 14'h0002);
    chk("deselect", 17'h0, {13'h0, bank_open_o});
  endtask : t_pre

  task automatic t_sref();
    logic [3:0] r0;
    r0 = refresh_row_o;
    cmd1(dcm_pkg::CMD_REF, 3'h3, 14'h3fff);
    chk("refresh row", 17'(4'(r0 + 4'h1)), {13'h0, refresh_row_o});
    u_ctrl.issue(dcm_pkg::CMD_REF, 3'h0, 14'h0000, 1'b0);
    #1;
    chk("sref entry", 17'h2, {15'h0, self_refresh_o, dll_enabled_o});
    u_ctrl.issue(dcm_pkg::CMD_ACT, 3'h1, 14'h0002, 1'b0);
    #1;
    chk("sref ignores", 17'h0, {13'h0, bank_open_o});
    cmd1(4'h7, 3'h0, 14'h0000);
    chk("sref exit", 17'h1, {15'h0, self_refresh_o, dll_enabled_o});
    cmd1(dcm_pkg::CMD_ACT, 3'h1, 14'h0002);
    rd(2'h1, 2'h2, 4'h8, 1'b0);
  endtask : t_sref

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_mode();
    t_rw();
    t_mask();
    t_posted();
    t_ap();
    t_pre();
    t_sref();
    conclude();
  end

  initial begin
    #3000000;
    num_errors++;
    conclude();
  end
endmodule : test_ddr2_command_and_mode_logic
